// ===== hdl/ccrg_pkg.sv
/*
 * Shared constants for the core clock ratio generator: widths, port
 * indices, ratio table, reset values, timing counts and the state type.
 * Assumes a single 100 MHz design clock that stands for the core clock.
 */
`default_nettype none

package ccrg_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_US = 1000;
	localparam int PLL_LOCK_TIME_US = 100;
	// least time, so round up
	localparam int PLL_LOCK_CYCLES =
		(PLL_LOCK_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CNT_W = 16;

	// ==========================================================
	// widths
	localparam int CFG_W = 2;
	localparam int MULT_W = 4;
	localparam int RATIO_W = 16;
	localparam int LINK_FIELD_W = 2;
	localparam int NUM_LINK = 2;
	localparam int NUM_SERIAL = 2;
	localparam int SERIAL_DIV_W = 15;
	localparam int SPI_DIV_W = 8;
	localparam int IRQ_W = 3;
	localparam int FLAG_W = 12;
	localparam int NUM_PORTS = 6;

	// ==========================================================
	// divided port clock slots
	localparam int PORT_LINK0 = 0;
	localparam int PORT_SERIAL0 = 2;
	localparam int PORT_SDRAM = 4;
	localparam int PORT_SPI = 5;
	localparam int SDRAM_HALF_BIT = 0;

	// ==========================================================
	// pll multiply ratio per config pin code
	localparam logic [MULT_W-1:0] MULT_CFG_00 = 4'h2;
	localparam logic [MULT_W-1:0] MULT_CFG_01 = 4'h3;
	localparam logic [MULT_W-1:0] MULT_CFG_10 = 4'h4;
	localparam logic [MULT_W-1:0] MULT_CFG_11 = 4'h1;
	localparam logic [MULT_W-1:0] MULT_RESET = 4'h1;
	localparam logic [MULT_W-1:0] MULT_ONE = 4'h1;
	localparam logic [RATIO_W-1:0] RATIO_ONE = 16'h0001;

	// ==========================================================
	// sequencing
	typedef enum logic [1:0] {
		ST_CAPTURE = 2'b00,
		ST_LOCKING = 2'b01,
		ST_RUN = 2'b10
	} ccrg_state_type;

endpackage : ccrg_pkg

`default_nettype wire

// ===== hdl/ccrg_port_divider.sv
/*
 * One programmable port clock divider: a tick each ratio_in core cycles
 * and a level that is high for the first half of each period.
 * Assumes ratio_in is at least one and run_in stays low until lock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccrg_port_divider
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic run_in,
	input wire logic [ccrg_pkg::RATIO_W-1:0] ratio_in,
	output logic tick_out,
	output logic level_out
);
	import ccrg_pkg::*;

	logic [RATIO_W-1:0] cnt_ff;
	logic [RATIO_W-1:0] nxt_cnt;
	logic [RATIO_W-1:0] half;
	logic tick_ff;
	logic level_ff;

	// ==========================================================
	// period counter
	always_comb
	begin
		half = (ratio_in + RATIO_ONE) >> 1;
		// a shrinking ratio must not strand the count above the limit
		if (!run_in)
			nxt_cnt = '0;
		else if (cnt_ff >= ratio_in - RATIO_ONE)
			nxt_cnt = '0;
		else
			nxt_cnt = cnt_ff + RATIO_ONE;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	// ==========================================================
	// outputs held low while stopped, so no runt pulse escapes
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tick_ff <= 1'b0;
			level_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= run_in && (cnt_ff == '0);
			level_ff <= run_in && (cnt_ff < half);
		end
	end

	assign tick_out = tick_ff;
	assign level_out = level_ff;

endmodule : ccrg_port_divider

`default_nettype wire

// ===== hdl/ccrg_core_clock_gen.sv
/*
 * Core clock ratio generation: captures the ratio straps at reset, waits
 * for pll lock, then makes system clock, port clocks and pin timing.
 * Assumes clk_in is the core clock; slower clocks are enable pulses.
 */
// What this block does
// - core to input ratios 1, 2, 3, 4, 6 and 8 are supported.
// - ratio straps are set by the board and taken at the first edge after reset release.
// - doubler strap low doubles system and pll input clock.
// - core clock is pll input clock times strap multiply ratio.
// - system clock output clocks the external port from pll input.
// - core clock times memory, core, link, serial and async strobes.
// - each serial and link port divides core clock by its setting plus one.
// - link clock period is core period times 1 to 4 by field.
// - serial clock period is core period times wide divider setting plus one.
// - sdram clock period is core period or twice by control bit.
// - spi clock period is core period times wide spi setting plus one.
// - shared bus arbitration resynchronises alone after reset.
// - interrupt meeting setup at system clock edge seen next cycle.
// - flag input sampled in cycle N steers conditions in N+2.
// - flag and timer outputs change only at system clock edges.
`timescale 1ns/1ps
`default_nettype none

module ccrg_core_clock_gen
#(
	parameter int LOCK_CYCLES = ccrg_pkg::PLL_LOCK_CYCLES
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic input_doubler_select_in,
	input wire logic [ccrg_pkg::CFG_W-1:0] pll_ratio_config_pins_in,
	input wire logic [ccrg_pkg::NUM_LINK*ccrg_pkg::LINK_FIELD_W-1:0]
		link_port_divide_field_in,
	input wire logic [ccrg_pkg::NUM_SERIAL*ccrg_pkg::SERIAL_DIV_W-1:0]
		serial_clock_divide_setting_in,
	input wire logic sdram_control_register_in,
	input wire logic [ccrg_pkg::SPI_DIV_W-1:0] spi_control_register_in,
	input wire logic [ccrg_pkg::IRQ_W-1:0] external_interrupt_inputs_b_in,
	input wire logic [ccrg_pkg::FLAG_W-1:0] general_purpose_flag_pins_in,
	input wire logic [ccrg_pkg::FLAG_W-1:0] flag_drive_value_in,
	input wire logic [ccrg_pkg::FLAG_W-1:0] flag_drive_enable_in,
	input wire logic timer_expired_in,
	output logic pll_locked_out,
	output logic core_clock_en_out,
	output logic pll_input_clock_tick_out,
	output logic external_port_system_clock_out,
	output logic input_reference_clock_tick_out,
	output logic [ccrg_pkg::MULT_W-1:0] core_to_input_ratio_out,
	output logic [ccrg_pkg::NUM_PORTS-1:0] port_clock_tick_out,
	output logic [ccrg_pkg::NUM_PORTS-1:0] port_clock_level_out,
	output logic [ccrg_pkg::IRQ_W-1:0] interrupt_request_out,
	output logic [ccrg_pkg::FLAG_W-1:0] flag_condition_out,
	output logic [ccrg_pkg::FLAG_W-1:0] general_purpose_flag_pins_out,
	output logic [ccrg_pkg::FLAG_W-1:0] general_purpose_flag_pins_oe_out,
	output logic timer_expired_output_out
);
	import ccrg_pkg::*;

	// every check in this module runs on the core clock, quiet in reset
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	localparam logic [LOCK_CNT_W-1:0] LOCK_LAST =
		LOCK_CNT_W'(LOCK_CYCLES - 1);

	// ==========================================================
	// helpers
	function automatic logic [MULT_W-1:0] ccrg_mult_of(
		input logic [CFG_W-1:0] cfg);
		logic [MULT_W-1:0] m;
		case (cfg)
			2'h0: m = MULT_CFG_00;
			2'h1: m = MULT_CFG_01;
			2'h2: m = MULT_CFG_10;
			default: m = MULT_CFG_11;
		endcase
		return m;
	endfunction : ccrg_mult_of

	function automatic logic [MULT_W-1:0] ccrg_ratio_of(
		input logic [CFG_W-1:0] cfg,
		input logic doubled);
		logic [MULT_W-1:0] m;
		m = ccrg_mult_of(cfg);
		return doubled ? {m[MULT_W-2:0], 1'b0} : m;
	endfunction : ccrg_ratio_of

	ccrg_state_type state_ff;
	ccrg_state_type nxt_state;
	logic [LOCK_CNT_W-1:0] lock_cnt_ff;
	logic [MULT_W-1:0] mult_ff;
	logic dbl_ff;
	logic [MULT_W-1:0] ratio_ff;
	logic running;
	logic [MULT_W-1:0] sys_cnt_ff;
	logic [MULT_W-1:0] sys_half;
	logic sys_tick;
	logic sys_tick_ff;
	logic sys_clk_ff;
	logic ref_phase_ff;
	logic ref_tick_ff;
	logic [IRQ_W-1:0] irq_ff;
	logic [FLAG_W-1:0] flag_s1_ff;
	logic [FLAG_W-1:0] flag_cond_ff;
	logic [FLAG_W-1:0] flag_out_ff;
	logic [FLAG_W-1:0] flag_oe_ff;
	logic timer_ff;
	logic [RATIO_W-1:0] ratio_vec [NUM_PORTS];

	// ==========================================================
	// reset, strap capture and lock sequencing
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_CAPTURE: nxt_state = ST_LOCKING;
			ST_LOCKING:
				if (lock_cnt_ff == LOCK_LAST)
					nxt_state = ST_RUN;
			ST_RUN: nxt_state = ST_RUN;
			default: nxt_state = ST_CAPTURE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			state_ff <= ST_CAPTURE;
		else
			state_ff <= nxt_state;
	end

	// lock time counted from reset release as a stand-in for the pll
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			lock_cnt_ff <= '0;
		else if (state_ff == ST_LOCKING)
			lock_cnt_ff <= lock_cnt_ff + 16'h0001;
	end

	// straps caught at the first edge after release, then frozen
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			mult_ff <= MULT_RESET;
			dbl_ff <= 1'b0;
			ratio_ff <= MULT_RESET;
		end
		else if (state_ff == ST_CAPTURE)
		begin
			mult_ff <= ccrg_mult_of(pll_ratio_config_pins_in);
			dbl_ff <= !input_doubler_select_in;
			ratio_ff <= ccrg_ratio_of(pll_ratio_config_pins_in,
				!input_doubler_select_in);
		end
	end

	assign running = (state_ff == ST_RUN);
	assign pll_locked_out = running;
	// core enable paces memory, core, ports and async strobes
	assign core_clock_en_out = running;
	assign core_to_input_ratio_out = ratio_ff;

	// ==========================================================
	// system clock and pll input clock, one and the same
	// phase starts fresh at release, so shared bus arbiters line up alone
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			sys_cnt_ff <= '0;
		else if (!running || sys_cnt_ff == mult_ff - MULT_ONE)
			sys_cnt_ff <= '0;
		else
			sys_cnt_ff <= sys_cnt_ff + MULT_ONE;
	end

	assign sys_half = (mult_ff + MULT_ONE) >> 1;
	assign sys_tick = running && (sys_cnt_ff == '0);

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sys_tick_ff <= 1'b0;
			sys_clk_ff <= 1'b0;
		end
		else
		begin
			sys_tick_ff <= sys_tick;
			sys_clk_ff <= running && (sys_cnt_ff < sys_half);
		end
	end

	// doubled mode: two pll input periods per reference period
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ref_phase_ff <= 1'b0;
			ref_tick_ff <= 1'b0;
		end
		else
		begin
			if (sys_tick && dbl_ff)
				ref_phase_ff <= !ref_phase_ff;
			ref_tick_ff <= sys_tick && (!dbl_ff || !ref_phase_ff);
		end
	end

	assign pll_input_clock_tick_out = sys_tick_ff;
	assign external_port_system_clock_out = sys_clk_ff;
	assign input_reference_clock_tick_out = ref_tick_ff;

	// ==========================================================
	// per-port divided clocks
	always_comb
	begin
		for (int i = 0; i < NUM_LINK; i++)
			ratio_vec[PORT_LINK0 + i] = RATIO_ONE + RATIO_W'(
				link_port_divide_field_in[i*LINK_FIELD_W +: LINK_FIELD_W]
			);
		for (int i = 0; i < NUM_SERIAL; i++)
			ratio_vec[PORT_SERIAL0 + i] = RATIO_ONE + RATIO_W'(
				serial_clock_divide_setting_in[i*SERIAL_DIV_W +: SERIAL_DIV_W]
			);
		ratio_vec[PORT_SDRAM] = RATIO_ONE +
			RATIO_W'(sdram_control_register_in);
		ratio_vec[PORT_SPI] = RATIO_ONE +
			RATIO_W'(spi_control_register_in);
	end

	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		ccrg_port_divider u_div
		(
			.clk_in(clk_in),
			.rst_b_in(rst_b_in),
			.run_in(running),
			.ratio_in(ratio_vec[p]),
			.tick_out(port_clock_tick_out[p]),
			.level_out(port_clock_level_out[p])
		);
	end

	// ==========================================================
	// pin timing against the system clock
	// a short interrupt between two edges is missed by design
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			irq_ff <= '0;
		else if (sys_tick)
			irq_ff <= ~external_interrupt_inputs_b_in;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			flag_s1_ff <= '0;
			flag_cond_ff <= '0;
		end
		else if (core_clock_en_out)
		begin
			flag_s1_ff <= general_purpose_flag_pins_in;
			flag_cond_ff <= flag_s1_ff;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			flag_out_ff <= '0;
			flag_oe_ff <= '0;
			timer_ff <= 1'b0;
		end
		else if (sys_tick)
		begin
			flag_out_ff <= flag_drive_value_in;
			flag_oe_ff <= flag_drive_enable_in;
			timer_ff <= timer_expired_in;
		end
	end

	assign interrupt_request_out = irq_ff;
	assign flag_condition_out = flag_cond_ff;
	assign general_purpose_flag_pins_out = flag_out_ff;
	assign general_purpose_flag_pins_oe_out = flag_oe_ff;
	assign timer_expired_output_out = timer_ff;

	// ==========================================================
	// checks
	logic [RATIO_W-1:0] gap_ff [NUM_PORTS];
	logic [RATIO_W-1:0] prev_ff [NUM_PORTS];
	logic [NUM_PORTS-1:0] seen_ff;
	logic [MULT_W-1:0] sys_gap_ff;
	logic sys_seen_ff;

	// cycles since the last tick; seen flag cleared whenever the ratio moves
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			seen_ff <= '0;
			sys_seen_ff <= 1'b0;
			sys_gap_ff <= '0;
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				gap_ff[p] <= '0;
				prev_ff[p] <= '0;
			end
		end
		else
		begin
			sys_gap_ff <= sys_tick_ff ? '0 : sys_gap_ff + MULT_ONE;
			if (sys_tick_ff)
				sys_seen_ff <= 1'b1;
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				prev_ff[p] <= ratio_vec[p];
				if (ratio_vec[p] != prev_ff[p])
					seen_ff[p] <= 1'b0;
				else if (port_clock_tick_out[p])
					seen_ff[p] <= 1'b1;
				gap_ff[p] <= port_clock_tick_out[p] ? '0 : gap_ff[p] + RATIO_ONE;
			end
		end
	end

	property p_ratio_legal;
		running |-> core_to_input_ratio_out inside
			{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
	endproperty
	a_ratio_legal: assert property (p_ratio_legal)
		else $error("core to input ratio not supported");

	property p_strap_frozen;
		running && $past(running) |-> $stable(core_to_input_ratio_out);
	endproperty
	a_strap_frozen: assert property (p_strap_frozen)
		else $error("ratio moved after capture");

	property p_doubled;
		rst_b_in && state_ff == ST_CAPTURE && !input_doubler_select_in |=>
			core_to_input_ratio_out ==
			{ccrg_mult_of($past(pll_ratio_config_pins_in)), 1'b0};
	endproperty
	a_doubled: assert property (p_doubled)
		else $error("doubler strap not applied");

	property p_sys_period;
		sys_tick_ff && sys_seen_ff |-> sys_gap_ff == mult_ff - MULT_ONE;
	endproperty
	a_sys_period: assert property (p_sys_period)
		else $error("system clock period wrong");

	property p_sys_edge;
		$rose(external_port_system_clock_out) |-> pll_input_clock_tick_out;
	endproperty
	a_sys_edge: assert property (p_sys_edge)
		else $error("system clock edge off pll input tick");

	property p_link_period;
		port_clock_tick_out[PORT_LINK0] && seen_ff[PORT_LINK0] &&
			$stable(link_port_divide_field_in) |->
			gap_ff[PORT_LINK0] ==
			RATIO_W'(link_port_divide_field_in[LINK_FIELD_W-1:0]);
	endproperty
	a_link_period: assert property (p_link_period)
		else $error("link clock period wrong");

	property p_serial_period;
		port_clock_tick_out[PORT_SERIAL0] && seen_ff[PORT_SERIAL0] &&
			$stable(serial_clock_divide_setting_in) |->
			gap_ff[PORT_SERIAL0] ==
			RATIO_W'(serial_clock_divide_setting_in[SERIAL_DIV_W-1:0]);
	endproperty
	a_serial_period: assert property (p_serial_period)
		else $error("serial clock period wrong");

	property p_sdram_period;
		port_clock_tick_out[PORT_SDRAM] && seen_ff[PORT_SDRAM] &&
			$stable(sdram_control_register_in) |->
			gap_ff[PORT_SDRAM] == RATIO_W'(sdram_control_register_in);
	endproperty
	a_sdram_period: assert property (p_sdram_period)
		else $error("sdram clock period wrong");

	property p_spi_period;
		port_clock_tick_out[PORT_SPI] && seen_ff[PORT_SPI] &&
			$stable(spi_control_register_in) |->
			gap_ff[PORT_SPI] == RATIO_W'(spi_control_register_in);
	endproperty
	a_spi_period: assert property (p_spi_period)
		else $error("spi clock period wrong");

	property p_irq_next;
		sys_tick |=>
			interrupt_request_out == ~$past(external_interrupt_inputs_b_in);
	endproperty
	a_irq_next: assert property (p_irq_next)
		else $error("interrupt not seen in following cycle");

	property p_flag_latency;
		running && $past(running, 2) |->
			flag_condition_out == $past(general_purpose_flag_pins_in, 2);
	endproperty
	a_flag_latency: assert property (p_flag_latency)
		else $error("flag input latency not two cycles");

	property p_pins_on_edge;
		!sys_tick |=> $stable(general_purpose_flag_pins_out) &&
			$stable(general_purpose_flag_pins_oe_out) &&
			$stable(timer_expired_output_out);
	endproperty
	a_pins_on_edge: assert property (p_pins_on_edge)
		else $error("flag or timer pin moved off system edge");

	property p_quiet;
		!pll_locked_out |-> port_clock_tick_out == '0 &&
			!pll_input_clock_tick_out && !external_port_system_clock_out &&
			!core_clock_en_out;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("derived clock active before lock");

endmodule : ccrg_core_clock_gen

`default_nettype wire

// ===== tb/ccrg_board_model.sv
/*
 * Board side of the clock generator: reset source and ratio straps.
 * Assumes the bench clock stands for the core clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module ccrg_board_model
(
	input wire logic clk_in,
	output logic rst_b_out,
	output logic doubler_out,
	output logic [1:0] cfg_out
);
	initial
	begin
		rst_b_out = 1'b0;
		doubler_out = 1'b1;
		cfg_out = 2'h0;
	end

	// ==========================================================
	// reset pulse with straps
	task automatic apply_reset(input logic [1:0] cfg, input logic dbl,
		input int hold);
		@(posedge clk_in);
		rst_b_out <= 1'b0;
		cfg_out <= cfg;
		doubler_out <= dbl;
		// hold sets the reset pulse length only; lock time is counted after release
		repeat (hold) @(posedge clk_in);
		rst_b_out <= 1'b1;
		@(posedge clk_in);
		// straps are no longer held, so show the opposite level
		cfg_out <= ~cfg;
		doubler_out <= ~dbl;
	endtask : apply_reset
endmodule : ccrg_board_model

`default_nettype wire

// ===== tb/ccrg_core_clock_gen_tb_top.sv
/*
 * Self-checking bench for the core clock ratio generator.
 * Assumes the board model drives reset and straps; bench drives the rest.
 */
`timescale 1ns/1ps
`default_nettype none

module ccrg_core_clock_gen_tb_top;
	import ccrg_pkg::*;
	localparam int LOCK = 20;
	logic clk_in = 1'b0;
	logic rst_b, dbl;
	logic [1:0] cfg;
	logic [3:0] link_fld = 4'h0;
	logic [29:0] ser_div = 30'h0;
	logic sd_bit = 1'b0;
	logic [7:0] spi_div = 8'h0;
	logic [2:0] irq_b = 3'h7;
	logic [11:0] flg_in = 12'h0, fdv = 12'h0, fde = 12'h0, h1, h2;
	logic tmr = 1'b0;
	logic locked, core_en, sys_tick, sysclk, ref_tick, tmo;
	logic [3:0] ratio;
	logic [5:0] ptick, plvl;
	logic [2:0] irq_req;
	logic [11:0] fcond, fpo, foe;
	logic [27:0] prev_in, last_out;
	wire logic [7:0] tick_vec = {ref_tick, sys_tick, ptick};
	wire logic [7:0] lvl_vec = {1'b0, sysclk, plvl};
	int failures = 0;
	int compares = 0;
	bit mon_on = 1'b0;

	initial
	begin
		forever #5 clk_in = ~clk_in;
	end

	ccrg_board_model i_ccrg_board_model (.clk_in(clk_in),
		.rst_b_out(rst_b), .doubler_out(dbl), .cfg_out(cfg));

	ccrg_core_clock_gen #(.LOCK_CYCLES(LOCK)) i_ccrg_core_clock_gen (
		.clk_in(clk_in), .rst_b_in(rst_b),
		.input_doubler_select_in(dbl), .pll_ratio_config_pins_in(cfg),
		.link_port_divide_field_in(link_fld),
		.serial_clock_divide_setting_in(ser_div),
		.sdram_control_register_in(sd_bit),
		.spi_control_register_in(spi_div),
		.external_interrupt_inputs_b_in(irq_b),
		.general_purpose_flag_pins_in(flg_in),
		.flag_drive_value_in(fdv), .flag_drive_enable_in(fde),
		.timer_expired_in(tmr), .pll_locked_out(locked),
		.core_clock_en_out(core_en),
		.pll_input_clock_tick_out(sys_tick),
		.external_port_system_clock_out(sysclk),
		.input_reference_clock_tick_out(ref_tick),
		.core_to_input_ratio_out(ratio), .port_clock_tick_out(ptick),
		.port_clock_level_out(plvl), .interrupt_request_out(irq_req),
		.flag_condition_out(fcond), .general_purpose_flag_pins_out(fpo),
		.general_purpose_flag_pins_oe_out(foe),
		.timer_expired_output_out(tmo));

	// ==========================================================
	// checking helpers
	task automatic close_out();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	function automatic int exp_mult(input logic [1:0] c);
		case (c)
			2'h0: return int'(MULT_CFG_00);
			2'h1: return int'(MULT_CFG_01);
			2'h2: return int'(MULT_CFG_10);
			default: return int'(MULT_CFG_11);
		endcase
	endfunction : exp_mult

	function automatic int port_ratio(input int p);
		if (p < 2)
			return int'(link_fld[2*p +: 2]) + 1;
		if (p < 4)
			return int'(ser_div[15*(p-2) +: 15]) + 1;
		if (p == 4)
			return sd_bit ? 2 : 1;
		return int'(spi_div) + 1;
	endfunction : port_ratio

	task automatic wait_tick(input int idx);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		while (tick_vec[idx] !== 1'b1 && n < 600);
		if (tick_vec[idx] !== 1'b1)
		begin
			chk($sformatf("tick wait %0d", idx), 1, 0);
			close_out();
		end
	endtask : wait_tick

	// skips a possibly irregular period, then times one whole period
	task automatic measure(input int idx, input int r, input int hi_exp);
		int n;
		int hi;
		repeat (2) wait_tick(idx);
		hi = (lvl_vec[idx] === 1'b1) ? 1 : 0;
		n = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
			if (tick_vec[idx] !== 1'b1 && lvl_vec[idx] === 1'b1)
				hi++;
		end
		while (tick_vec[idx] !== 1'b1 && n < 600);
		chk($sformatf("period %0d", idx), r, n);
		if (tick_vec[idx] !== 1'b1)
			close_out();
		if (hi_exp > 0)
			chk($sformatf("high time %0d", idx), hi_exp, hi);
	endtask : measure

	// ==========================================================
	// random pin stimulus and per-cycle monitor
	always @(posedge clk_in)
	begin
		irq_b <= 3'($urandom);
		flg_in <= 12'($urandom);
		fdv <= 12'($urandom);
		fde <= 12'($urandom);
		tmr <= 1'($urandom);
	end

	always @(posedge clk_in)
	begin
		#1;
		if (locked !== 1'b1)
			chk("quiet ticks", 0, {ref_tick, sys_tick, ptick});
		if (mon_on)
		begin
			if (sys_tick === 1'b1)
				chk("pin sample", prev_in, {irq_req, fpo, foe, tmo});
			else
				chk("pin hold", last_out, {irq_req, fpo, foe, tmo});
			chk("flag condition", h2, fcond);
		end
		prev_in = {~irq_b, fdv, fde, tmr};
		last_out = {irq_req, fpo, foe, tmo};
		h2 = h1;
		h1 = flg_in;
	end

	// ==========================================================
	// one reset and lock per strap setting, then clock periods
	task automatic run_case(input int k);
		int n;
		int m;
		int r;
		@(posedge clk_in);
		mon_on = 1'b0;
		m = exp_mult(2'(k));
		// four system periods of m core cycles each at the least
		i_ccrg_board_model.apply_reset(2'(k), k[2], (k == 0) ? 16 : 4 * m);
		n = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		while (locked !== 1'b1 && n < LOCK + 10);
		chk("lock delay", LOCK, n);
		if (locked !== 1'b1)
			close_out();
		chk("core enable", 1, core_en);
		chk("core ratio", k[2] ? m : 2 * m, ratio);
		// flag pipe holds reset data until its second enabled edge
		@(posedge clk_in);
		@(posedge clk_in);
		mon_on = 1'b1;
		measure(6, m, (m + 1) / 2);
		measure(7, k[2] ? m : 2 * m, 0);
		@(posedge clk_in);
		link_fld <= (k == 7) ? 4'hf : 4'($urandom);
		ser_div <= (k == 0) ? 30'h0 :
			{15'($urandom_range(0, 40)), 15'($urandom_range(0, 40))};
		sd_bit <= (k == 0) ? 1'b0 : 1'($urandom);
		spi_div <= (k == 7) ? 8'hff :
			((k == 0) ? 8'h0 : 8'($urandom_range(0, 60)));
		@(posedge clk_in);
		for (int p = 0; p < 6; p++)
		begin
			r = port_ratio(p);
			measure(p, r, (r + 1) / 2);
		end
		chk("ratio after straps move", k[2] ? m : 2 * m, ratio);
	endtask : run_case

	initial
	begin
		void'($urandom(32'h1ae92542));
		for (int k = 0; k < 8; k++)
			run_case(k);
		close_out();
	end
endmodule : ccrg_core_clock_gen_tb_top

`default_nettype wire
